// ===== logic/usbio_regs.vh
// Register map, field positions and reset values for the USB-side I/O ports.
// Assumes inclusion by the port block; holds definitions only.
`ifndef USBIO_REGS_VH
`define USBIO_REGS_VH

// Register indices (spaced by one, not by four): byte address is four times these.
`define USBIO_IDX_C_OUT      16'hfe4c
`define USBIO_IDX_D_OUT      16'hfe4d
`define USBIO_IDX_C_DIR      16'hfe4e
`define USBIO_IDX_D_DIR      16'hfe4f
// Own control registers: hub power-switch pair enables and function-only select.
`define USBIO_IDX_HUB_OC     16'hfe50
`define USBIO_IDX_USB_CTRL   16'hfe51
// Standby control: bit 0 software standby, bit 1 hardware standby.
`define USBIO_IDX_STANDBY    16'hfe52

// Field positions.
`define USBIO_HUB_OC_EN_LSB  0
`define USBIO_HUB_OC_EN_MSB  3
`define USBIO_FUNCTION_ONLY_SELECT_BIT      0
`define USBIO_SW_STBY_BIT    0
`define USBIO_HW_STBY_BIT    1

// Reset values.
`define USBIO_RST_DIR        8'h00
`define USBIO_RST_OUT        8'h00
`define USBIO_RST_HUB_OC     4'h0
`define USBIO_RST_FUNCTION_ONLY_SELECT      1'b1

// Value returned for unmapped reads.
`define USBIO_UNDEF_READ     32'h0000_0000

`endif

// ===== logic/usbio_pin_mux.v
// One 8-pin port output stage: selects between general I/O and a shared function.
// Assumes registered inputs from the port block; outputs are flip-flops.
`timescale 1ns/1ns
`default_nettype none

module usbio_pin_mux #(
  parameter WIDTH = 8
) (
  // Clock and reset.
  input  wire             clock,
  input  wire             rst_n,
  // Select per pin: 1 gives the pin to the shared function.
  input  wire [WIDTH-1:0] func_sel,
  // General I/O controls.
  input  wire [WIDTH-1:0] gpio_dir,
  input  wire [WIDTH-1:0] gpio_out,
  // Shared function controls.
  input  wire [WIDTH-1:0] func_oe,
  input  wire [WIDTH-1:0] func_out,
  // Pad drive.
  output reg  [WIDTH-1:0] pad_out,
  output reg  [WIDTH-1:0] pad_oe
);

  // Each pin is chosen independently; a general input is left undriven.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_pin
      always @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pad_out[i] <= 1'b0;
          pad_oe[i]  <= 1'b0;
        end
        else if (func_sel[i])
        begin
          pad_out[i] <= func_out[i];
          pad_oe[i]  <= func_oe[i];
        end
        else
        begin
          pad_out[i] <= gpio_out[i];
          pad_oe[i]  <= gpio_dir[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== logic/usbio_ports.v
// Two 8-bit general I/O ports shared with hub power switch and hub downstream data.
// Assumes an APB master at 20 MHz and synchronous pad inputs.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "usbio_regs.vh"

module usbio_ports (
  // Clock and reset.
  input  wire        clock,
  input  wire        rst_n,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Port C pads.
  input  wire [7:0]  port_c_in,
  output wire [7:0]  port_c_out,
  output wire [7:0]  port_c_oe,
  // Port D pads.
  input  wire [7:0]  port_d_in,
  output wire [7:0]  port_d_out,
  output wire [7:0]  port_d_oe,
  // Hub power-switch side: enables from the hub and overcurrent seen by it.
  input  wire [3:0]  hub_power_enable,
  output reg  [3:0]  overcurrent_in_n,
  // Hub downstream data from and to the USB controller.
  input  wire [7:0]  hub_data_out,
  input  wire [7:0]  hub_data_oe,
  output reg  [7:0]  hub_data_in,
  // Mode status.
  output reg         function_only_select
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [7:0]  port_c_direction_q;
  reg  [7:0]  port_c_output_latch_q;
  reg  [7:0]  port_d_direction_q;
  reg  [7:0]  port_d_output_latch_q;
  reg  [3:0]  hub_overcurrent_control_q;
  reg  [1:0]  standby_q;
  reg  [31:0] prdata_d;
  reg         pslverr_d;
  wire        hw_standby;
  wire        wr_en;
  wire        rd_en;
  wire [15:0] reg_idx;
  wire        addr_ok;
  wire [7:0]  c_func_sel;
  wire [7:0]  c_func_out;
  wire [7:0]  c_func_oe;
  wire [7:0]  d_func_sel;

  // Decodes a byte address into its printed index when word aligned in the map.
  function [16:0] usbio_decode;
    input [31:0] addr;
    begin
      usbio_decode = {(addr[1:0] == 2'b00) && (addr[31:18] == 14'h0000), addr[17:2]};
    end
  endfunction

  assign {addr_ok, reg_idx} = usbio_decode(paddr);
  assign wr_en              = psel & penable & pwrite & pready;
  assign rd_en              = psel & penable & ~pwrite & pready;
  assign hw_standby         = standby_q[`USBIO_HW_STBY_BIT];

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------

  // Ready rises in the access phase, giving one wait state per transfer.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pready <= 1'b0;
    else
      pready <= psel & penable & ~pready;
  end

  // ----------------------------------------------------------------
  // Port registers
  // ----------------------------------------------------------------

  // Hardware standby clears the port registers; software standby leaves them alone.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_c_direction_q    <= `USBIO_RST_DIR;
      port_c_output_latch_q <= `USBIO_RST_OUT;
      port_d_direction_q    <= `USBIO_RST_DIR;
      port_d_output_latch_q <= `USBIO_RST_OUT;
    end
    else if (hw_standby)
    begin
      port_c_direction_q    <= `USBIO_RST_DIR;
      port_c_output_latch_q <= `USBIO_RST_OUT;
      port_d_direction_q    <= `USBIO_RST_DIR;
      port_d_output_latch_q <= `USBIO_RST_OUT;
    end
    else if (wr_en && addr_ok)
    begin
      case (reg_idx)
        `USBIO_IDX_C_OUT: port_c_output_latch_q <= pwdata[7:0];
        `USBIO_IDX_D_OUT: port_d_output_latch_q <= pwdata[7:0];
        `USBIO_IDX_C_DIR: port_c_direction_q    <= pwdata[7:0];
        `USBIO_IDX_D_DIR: port_d_direction_q    <= pwdata[7:0];
        default:          port_c_direction_q    <= port_c_direction_q;
      endcase
    end
  end

  // Control registers: pair enables, function-only bit and standby requests.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hub_overcurrent_control_q <= `USBIO_RST_HUB_OC;
      function_only_select      <= `USBIO_RST_FUNCTION_ONLY_SELECT;
      standby_q                 <= 2'b00;
    end
    else if (wr_en && addr_ok)
    begin
      case (reg_idx)
        `USBIO_IDX_HUB_OC:
          hub_overcurrent_control_q <= pwdata[`USBIO_HUB_OC_EN_MSB:`USBIO_HUB_OC_EN_LSB];
        `USBIO_IDX_USB_CTRL:
          function_only_select <= pwdata[`USBIO_FUNCTION_ONLY_SELECT_BIT];
        `USBIO_IDX_STANDBY:
          standby_q <= pwdata[1:0];
        default:
          standby_q <= standby_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Shared addresses return pin levels; direction itself is never readable.
  always @*
  begin
    prdata_d  = `USBIO_UNDEF_READ;
    pslverr_d = 1'b0;
    if (!addr_ok)
      pslverr_d = 1'b1;
    else
    begin
      case (reg_idx)
        `USBIO_IDX_C_OUT:    prdata_d = {24'h000000, port_c_output_latch_q};
        `USBIO_IDX_D_OUT:    prdata_d = {24'h000000, port_d_output_latch_q};
        `USBIO_IDX_C_DIR:    prdata_d = {24'h000000, port_c_in};
        `USBIO_IDX_D_DIR:    prdata_d = {24'h000000, port_d_in};
        `USBIO_IDX_HUB_OC:   prdata_d = {28'h0000000, hub_overcurrent_control_q};
        `USBIO_IDX_USB_CTRL: prdata_d = {31'h00000000, function_only_select};
        `USBIO_IDX_STANDBY:  prdata_d = {30'h00000000, standby_q};
        default:             pslverr_d = 1'b1;
      endcase
    end
  end

  // Read data and error are registered and stand with the ready cycle.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready)
    begin
      prdata  <= pwrite ? 32'h00000000 : prdata_d;
      pslverr <= pslverr_d;
    end
    else
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Shared functions
  // ----------------------------------------------------------------

  // Each enabled pair takes its overcurrent input (upper) and enable output (lower).
  assign c_func_sel = {hub_overcurrent_control_q, hub_overcurrent_control_q};
  assign c_func_out = {4'h0, ~hub_power_enable};
  assign c_func_oe  = {4'h0, 4'hf};

  // Hub downstream data owns port D while function-only is cleared.
  assign d_func_sel = {8{~function_only_select}};

  // Overcurrent reports are forwarded active low; a disabled pair reads inactive.
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overcurrent_in_n <= 4'hf;
      hub_data_in      <= 8'h00;
    end
    else
    begin
      overcurrent_in_n <= port_c_in[7:4] | ~hub_overcurrent_control_q;
      hub_data_in      <= function_only_select ? 8'h00 : port_d_in;
    end
  end

  // ----------------------------------------------------------------
  // Pad stages
  // ----------------------------------------------------------------

  // Port C: direction bit 1 drives, 0 listens, unless the pair is switched over.
  usbio_pin_mux #(
    .WIDTH (8)
  ) u_port_c (
    .clock    (clock),
    .rst_n    (rst_n),
    .func_sel (c_func_sel),
    .gpio_dir (port_c_direction_q),
    .gpio_out (port_c_output_latch_q),
    .func_oe  (c_func_oe),
    .func_out (c_func_out),
    .pad_out  (port_c_out),
    .pad_oe   (port_c_oe)
  );

  // Port D: general I/O when function-only, otherwise hub downstream data.
  usbio_pin_mux #(
    .WIDTH (8)
  ) u_port_d (
    .clock    (clock),
    .rst_n    (rst_n),
    .func_sel (d_func_sel),
    .gpio_dir (port_d_direction_q),
    .gpio_out (port_d_output_latch_q),
    .func_oe  (hub_data_oe),
    .func_out (hub_data_out),
    .pad_out  (port_d_out),
    .pad_oe   (port_d_oe)
  );

endmodule

`default_nettype wire

// ===== test/usbio_switch_model.sv
// Behavioural hub port power switch, four channels.
// Assumes the bench pulls released enable lines high.
`timescale 1ns/1ns
`default_nettype none
module usbio_switch_model (
  // Enables from the port, active low.
  input  wire logic [3:0] en_n,
  // Faults commanded by the bench.
  input  wire logic [3:0] fault,
  // Overcurrent flags to the port, active low.
  output logic      [3:0] oc_n
);
  // A channel flags only while switched on and faulted.
  assign oc_n = ~(fault & ~en_n);
endmodule
`default_nettype wire

// ===== test/usbio_checker.sv
// Concurrent checks on the I/O port block's ports.
// Assumes one APB wait state and registered pads.
`timescale 1ns/1ns
`default_nettype none
module usbio_checker (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rst_n,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pads.
  input wire logic [7:0]  port_c_in,
  input wire logic [7:0]  port_c_out,
  input wire logic [7:0]  port_c_oe,
  input wire logic [7:0]  port_d_in,
  input wire logic [7:0]  port_d_out,
  input wire logic [7:0]  port_d_oe,
  // Hub side.
  input wire logic [3:0]  hub_power_enable,
  input wire logic [3:0]  overcurrent_in_n,
  input wire logic [7:0]  hub_data_out,
  input wire logic [7:0]  hub_data_oe,
  input wire logic [7:0]  hub_data_in,
  input wire logic        function_only_select
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Setup cycle followed by the first access cycle.
  sequence setup_acc;
    psel && !penable && !pready ##1 psel && penable;
  endsequence
  ready_timing_a: assert property (setup_acc |=> pready)
    else $error("answer missing one cycle into access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  ready_in_acc_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");
  idle_rdata_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read answer");
  c_pins_read_a: assert property (pready && !pwrite && paddr == 32'h3f938
    |-> prdata == {24'h0, $past(port_c_in)}) else $error("port c read is not pin levels");
  d_pins_read_a: assert property (pready && !pwrite && paddr == 32'h3f93c
    |-> prdata == {24'h0, $past(port_d_in)}) else $error("port d read is not pin levels");
  oc_cause_a: assert property ((~overcurrent_in_n & $past(port_c_in[7:4])) == 4'h0)
    else $error("overcurrent flagged with pin high");
  hub_in_a: assert property (hub_data_in ==
    ($past(function_only_select) ? 8'h00 : $past(port_d_in))) else $error("hub data path wrong");
endmodule
bind usbio_ports usbio_checker i_usbio_checker (.*);
`default_nettype wire

// ===== test/usbio_ports_tb.sv
// Self-checking bench for the USB-side I/O port block.
// Assumes the register header is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "usbio_regs.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module usbio_ports_tb;
  logic        clock, rst_n, psel, penable, pwrite, err;
  logic [31:0] paddr, pwdata, rd;
  logic [7:0]  d_ext, hd_out, hd_oe;
  logic [3:0]  hpe, fault;
  int          err_total, checks;
  wire logic [31:0] prdata;
  wire logic        pready, pslverr, fos;
  wire logic [7:0]  c_out, c_oe, d_out, d_oe, c_pin, d_pin, hd_in;
  wire logic [3:0]  ocn, oc_n;
  // Rows: {err, write} nibble, offset from the C latch index, data.
  logic [15:0] rows [13] = '{16'h0000, 16'h0100, 16'h10a5, 16'h00a5, 16'h113c, 16'h013c,
    16'h02ff, 16'h0396, 16'h120f, 16'h02f5, 16'h13f0, 16'h0336, 16'h2700};
  // Wire levels: pull-ups on enables, switch on flags, bench on port d.
  assign c_pin[3:0] = c_oe[3:0] & c_out[3:0] | ~c_oe[3:0];
  assign c_pin[7:4] = c_oe[7:4] & c_out[7:4] | ~c_oe[7:4] & oc_n;
  assign d_pin = d_oe & d_out | ~d_oe & d_ext;
  usbio_ports i_usbio_ports (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_c_in(c_pin), .port_c_out(c_out), .port_c_oe(c_oe),
    .port_d_in(d_pin), .port_d_out(d_out), .port_d_oe(d_oe), .hub_power_enable(hpe),
    .overcurrent_in_n(ocn), .hub_data_out(hd_out), .hub_data_oe(hd_oe),
    .hub_data_in(hd_in), .function_only_select(fos));
  usbio_switch_model i_usbio_switch_model (.en_n(c_pin[3:0]), .fault(fault), .oc_n(oc_n));
  // Clock of 50 ns.
  initial
  begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  // One APB transfer, held until ready is sampled.
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Lets registered pads follow, then samples away from the edge.
  task automatic settle;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Cuts a hang short.
  initial
  begin
    #100000;
    err_total++;
    wrap_up;
  end
  // Main sequence.
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {hd_out, hd_oe, hpe, fault} = '0;
    d_ext = 8'h96;
    repeat (3) @(posedge clock);
    `CHK({c_oe, d_oe, ocn, fos}, 21'h1f)
    rst_n <= 1;
    foreach (rows[i])
    begin
      apb(rows[i][12], `USBIO_IDX_C_OUT + rows[i][11:8], rows[i][7:0]);
      if (!rows[i][12]) `CHK({err, rd}, {rows[i][13], 24'h0, rows[i][7:0]})
    end
    settle;
    `CHK({c_oe, c_out[3:0], d_oe, d_out[7:4]}, 24'h0f5f03)
    apb(1, `USBIO_IDX_C_DIR, 8'hff);
    hpe <= 4'h1;
    fault <= 4'h1;
    apb(1, `USBIO_IDX_HUB_OC, 8'h05);
    settle;
    `CHK({c_oe, c_out[3:0], ocn}, 16'haf4e)
    fault <= 4'h0;
    apb(1, `USBIO_IDX_HUB_OC, 8'h00);
    apb(1, `USBIO_IDX_STANDBY, 8'h01);
    apb(0, `USBIO_IDX_C_OUT, 8'h00);
    settle;
    `CHK({rd[7:0], c_oe}, 16'ha5ff)
    apb(1, `USBIO_IDX_STANDBY, 8'h02);
    apb(1, `USBIO_IDX_STANDBY, 8'h00);
    apb(0, `USBIO_IDX_D_OUT, 8'h00);
    settle;
    `CHK({rd[7:0], c_oe, d_oe}, 24'h0)
    hd_oe <= 8'hf0;
    hd_out <= 8'ha0;
    apb(1, `USBIO_IDX_USB_CTRL, 8'h00);
    settle;
    `CHK({fos, d_oe, d_out[7:4], hd_in}, 21'h0f0aa6)
    apb(1, `USBIO_IDX_USB_CTRL, 8'h01);
    settle;
    `CHK({fos, hd_in, d_oe}, 17'h10000)
    @(posedge clock);
    rst_n <= 0;
    @(negedge clock);
    `CHK({fos, ocn, c_oe}, 13'h1f00)
    wrap_up;
  end
endmodule
`default_nettype wire
